/* bench/bpc_root_model.sv */
// Root complex model issuing configuration reads and writes
`timescale 1ns/1ps
module bpc_root_model (
   input  wire logic             ref_clk,
   input  wire logic             cfgRvalid,
   input  wire logic [31:0]      cfgRdata,
   output bpc_pkg::bpc_cfg_req_t cfgReq
);
   initial cfgReq = '0;
   // Entered just after a rising edge; idle fields are inverted so strobes alone must gate
   task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d};
      @(posedge ref_clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [32:0] q);
      cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
      @(posedge ref_clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: 32'hFFFFFFFF};
      @(negedge ref_clk);
      q = {cfgRvalid, cfgRdata};
      @(posedge ref_clk);
   endtask
endmodule

/* bench/tb_bridge_port_command_gating.sv */
// Self-checking testbench for the bridge port command register
`timescale 1ns/1ps
module tb_bridge_port_command_gating;
   localparam logic [15:0] WR_MASK = 16'h0547;
   logic                  ref_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, ioHit = 1'b0, memHit = 1'b0;
   logic                  prefetchHit = 1'b0, ownIntxReq = 1'b0, secIntx = 1'b0;
   bpc_pkg::bpc_cfg_req_t cfgReq;
   bpc_pkg::bpc_up_req_t  upReq = '0;
   bpc_pkg::bpc_err_in_t  errIn = '0;
   logic [15:0]           command;
   logic [31:0]           cfgRdata, r, c, seed = 32'h0000E20A;
   logic [32:0]           q;
   logic [9:0]            g;
   logic                  serrStatus, cfgRvalid, ioClaim, memClaim, upForward, upUr, upUrCpl, sendNonFatal;
   logic                  sendFatal, sendCor, ownIntx, intxAssertMsg, intxDeassertMsg, fwdIntx;
   int                    n_fail = 0, check_count = 0, nDeassert = 0, nd = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   bpc_bridge_command dut_u (.ref_clk, .rst, .clkEn, .cfgReq, .ioHit, .memHit, .prefetchHit, .upReq, .errIn,
      .ownIntxReq, .secIntx, .command, .serrStatus, .cfgRdata, .cfgRvalid, .ioClaim, .memClaim, .upForward,
      .upUr, .upUrCpl, .sendNonFatal, .sendFatal, .sendCor, .ownIntx, .intxAssertMsg, .intxDeassertMsg, .fwdIntx);
   bpc_root_model root_u (.ref_clk, .cfgRvalid, .cfgRdata, .cfgReq);
   always @(posedge ref_clk) if (intxDeassertMsg === 1'b1) nDeassert <= nDeassert + 1;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Kind folded to the six legal codes; non-posted only on memory, I/O and MSI
   function automatic logic [9:0] expGate(input logic [15:0] k, input logic [31:0] s);
      logic mio;
      mio = (s[6:4] % 6) < 3;
      return {s[0] & k[0], (s[1] | s[2]) & k[1], s[3] & (k[2] | !mio), s[3] & !k[2] & mio,
         s[3] & !k[2] & mio & s[7], (s[14] & (k[8] | s[12])) | (s[10] & k[8]),
         (s[13] & (k[8] | s[11])) | (s[9] & k[8]), s[8], s[15] & !k[10], s[16]};
   endfunction
   task automatic drive(input logic [31:0] s);
      logic [2:0] kd;
      kd = 3'(s[6:4] % 6);
      {secIntx, ownIntxReq, errIn, ioHit, memHit, prefetchHit} <= {s[16:8], s[0], s[1], s[2]};
      upReq <= '{valid: s[3], kind: bpc_pkg::bpc_req_kind_t'(kd), nonPosted: s[7] & (kd < 3)};
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole sequence needs about 1240 cycles; generous margin
   initial begin
      #50000;
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      root_u.rd(12'h004, q);
      check({q[32], q[30], q[15:0]}, {1'b1, 1'b0, 16'h0000}, "reset value");
      root_u.wr(12'h004, 4'h3, 32'hFFFFFFFF);
      check(command, WR_MASK, "fixed bits written");
      root_u.wr(12'h004, 4'h2, 32'h0);
      check(command, 16'h0047, "byte enable");
      root_u.rd(12'h010, q);
      check(q, {1'b1, 32'h0}, "unmapped read");
      $display("register test done");
      for (int i = 0; i < 300; i++) begin
         c = rnd();
         root_u.wr(12'h004, 4'h3, c);
         r = rnd();
         check(command, c[15:0] & WR_MASK, "random write");
         drive(r);
         @(posedge ref_clk);
         @(negedge ref_clk);
         g = expGate(c[15:0] & WR_MASK, r);
         check({ioClaim, memClaim}, g[9:8], "window claims");
         check({upForward, upUr, upUrCpl}, g[7:5], "upstream gating");
         check({sendNonFatal, sendFatal, sendCor}, g[4:2], "error messages");
         check({ownIntx, fwdIntx}, g[1:0], "interrupts");
         @(posedge ref_clk);
         drive(32'h0);
      end
      $display("random gating test done");
      root_u.wr(12'h004, 4'h3, 32'h0);
      drive(32'h00018000);
      repeat (3) @(posedge ref_clk);
      nd = nDeassert;
      check(ownIntx, 1'b1, "own interrupt");
      root_u.wr(12'h004, 4'h3, 32'h0400);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check({nDeassert - nd == 1, ownIntx, fwdIntx}, 3'b101, "interrupt disable");
      @(posedge ref_clk);
      drive(32'h0);
      $display("interrupt test done");
      // Status clear first, since random traffic may have left it set
      root_u.wr(12'h004, 4'hF, 32'h40000100);
      drive(32'h00002000);
      @(posedge ref_clk);
      drive(32'h0);
      @(posedge ref_clk);
      root_u.rd(12'h004, q);
      check({q[30], q[15:0]}, 17'h10100, "status set");
      root_u.wr(12'h004, 4'h8, 32'h40000000);
      root_u.rd(12'h004, q);
      check({q[30], q[15:0]}, 17'h00100, "status cleared");
      $display("status test done");
      // Reset in mid-run must clear a command that is no longer zero
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      root_u.rd(12'h004, q);
      check({q[32], q[30], q[15:0]}, {1'b1, 1'b0, 16'h0000}, "mid-run reset");
      $display("reset test done");
      end_sim();
   end
endmodule

/* core/bpc_bridge_command.sv */
// Command register of one bridge port and the gating it applies
`timescale 1ns/1ps
// Functional notes
// - I/O window requests claimed only while I/O space enable is set.
// - Memory and prefetch window requests claimed only while memory space enable set.
// - Without bus mastering, upstream memory, I/O and MSI requests become Unsupported Request.
// - Without bus mastering, upstream non-posted memory, I/O and MSI requests get an Unsupported Request completion.
// - Bus mastering never blocks completions nor requests other than memory, I/O and MSI.
// - Own fatal/non-fatal errors reported if system-error enable or device control enable.
// - Secondary fatal/non-fatal messages forwarded only while system-error enable set.
// - Correctable error messages always forwarded upstream.
// - Interrupt disable deasserts own INTx, sending deassert message on state change.
// - Interrupt disable never affects forwarded secondary INTx.
// - Special-cycle, write-invalidate, palette-snoop, stepping, back-to-back bits read zero.
// - Parity error enable is stored and read back, no effect.
// - Every command field resets to zero, so all gating starts off.
// - Sending fatal/non-fatal with system-error enable sets status bit; write one clears.
module bpc_bridge_command (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  clkEn,
   input  wire bpc_pkg::bpc_cfg_req_t cfgReq,
   input  wire logic                  ioHit,
   input  wire logic                  memHit,
   input  wire logic                  prefetchHit,
   input  wire bpc_pkg::bpc_up_req_t  upReq,
   input  wire bpc_pkg::bpc_err_in_t  errIn,
   input  wire logic                  ownIntxReq,
   input  wire logic                  secIntx,
   output logic [15:0]                command,
   output logic                       serrStatus,
   output logic [31:0]                cfgRdata,
   output logic                       cfgRvalid,
   output logic                       ioClaim,
   output logic                       memClaim,
   output logic                       upForward,
   output logic                       upUr,
   output logic                       upUrCpl,
   output logic                       sendNonFatal,
   output logic                       sendFatal,
   output logic                       sendCor,
   output logic                       ownIntx,
   output logic                       intxAssertMsg,
   output logic                       intxDeassertMsg,
   output logic                       fwdIntx
);
   bpc_pkg::bpc_state_t st;
   bpc_pkg::bpc_state_t next_st;

   // Merge a byte-enabled write into a 16-bit field limited by a write mask
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be, input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
      return (old & ~lanes) | (wd & lanes);
   endfunction

   logic cmdSel;
   logic serrEn;
   logic memIo;
   logic intxGate;
   assign cmdSel   = cfgReq.addr == bpc_pkg::BRIDGE_COMMAND_OFFSET;
   assign serrEn   = st.command[bpc_pkg::SYSTEM_ERROR_ENABLE_BIT];
   assign memIo    = upReq.kind == bpc_pkg::BPC_REQ_MEM || upReq.kind == bpc_pkg::BPC_REQ_IO
                     || upReq.kind == bpc_pkg::BPC_REQ_MSI;
   assign intxGate = ownIntxReq & ~st.command[bpc_pkg::INTERRUPT_DISABLE_BIT];

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      if (cfgReq.wr && cmdSel) begin
         // Only bits 0,1,2,6,8,10 can change, so reserved and fixed bits stay zero
         next_st.command = merge16(st.command, cfgReq.wdata[15:0], cfgReq.be[1:0],
                                   bpc_pkg::BRIDGE_COMMAND_WMASK);
         if (cfgReq.be[3] && cfgReq.wdata[16 + bpc_pkg::SIGNALLED_SERR_BIT])
            next_st.serrStatus = 1'b0;
      end
      if (cfgReq.rd) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = cmdSel ? {1'b0, st.serrStatus, 14'h0000, st.command} : 32'h0000_0000;
      end
      next_st.ioClaim  = ioHit & st.command[bpc_pkg::IO_SPACE_ENABLE_BIT];
      next_st.memClaim = (memHit | prefetchHit) & st.command[bpc_pkg::MEMORY_SPACE_ENABLE_BIT];
      // Completions and other messages pass regardless of bus mastering
      next_st.upForward = upReq.valid & (~memIo | st.command[bpc_pkg::BUS_MASTERING_ENABLE_BIT]);
      next_st.upUr      = upReq.valid & memIo & ~st.command[bpc_pkg::BUS_MASTERING_ENABLE_BIT];
      next_st.upUrCpl   = upReq.valid & memIo & upReq.nonPosted
                          & ~st.command[bpc_pkg::BUS_MASTERING_ENABLE_BIT];
      next_st.sendNonFatal = (errIn.ownNonFatal & (serrEn | errIn.devNonFatalEn))
                             | (errIn.secNonFatal & serrEn);
      next_st.sendFatal    = (errIn.ownFatal & (serrEn | errIn.devFatalEn))
                             | (errIn.secFatal & serrEn);
      next_st.sendCor      = errIn.secCor;
      // Set wins over a same-cycle clear
      if ((next_st.sendNonFatal | next_st.sendFatal) & serrEn)
         next_st.serrStatus = 1'b1;
      next_st.ownIntx         = intxGate;
      next_st.intxAssertMsg   = intxGate & ~st.ownIntx;
      next_st.intxDeassertMsg = ~intxGate & st.ownIntx;
      next_st.fwdIntx         = secIntx;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   assign command         = st.command;
   assign serrStatus      = st.serrStatus;
   assign cfgRdata        = st.rdata;
   assign cfgRvalid       = st.rvalid;
   assign ioClaim         = st.ioClaim;
   assign memClaim        = st.memClaim;
   assign upForward       = st.upForward;
   assign upUr            = st.upUr;
   assign upUrCpl         = st.upUrCpl;
   assign sendNonFatal    = st.sendNonFatal;
   assign sendFatal       = st.sendFatal;
   assign sendCor         = st.sendCor;
   assign ownIntx         = st.ownIntx;
   assign intxAssertMsg   = st.intxAssertMsg;
   assign intxDeassertMsg = st.intxDeassertMsg;
   assign fwdIntx         = st.fwdIntx;

   property p_io_gate;
      @(posedge ref_clk) disable iff (rst)
      clkEn |=> ioClaim == ($past(ioHit) & $past(st.command[0]));
   endproperty
   a_io_gate: assert property (p_io_gate) else $error("io claim mismatch");

   property p_mem_gate;
      @(posedge ref_clk) disable iff (rst)
      clkEn && !st.command[1] |=> !memClaim;
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory claimed while disabled");

   property p_bm_ur;
      @(posedge ref_clk) disable iff (rst)
      clkEn && upReq.valid && memIo && !st.command[2] |=> upUr && !upForward;
   endproperty
   a_bm_ur: assert property (p_bm_ur) else $error("request not refused");

   property p_bm_cpl;
      @(posedge ref_clk) disable iff (rst)
      clkEn && upReq.valid && upReq.kind == bpc_pkg::BPC_REQ_CPL |=> upForward;
   endproperty
   a_bm_cpl: assert property (p_bm_cpl) else $error("completion blocked");

   property p_sec_fwd;
      @(posedge ref_clk) disable iff (rst)
      clkEn && errIn.secFatal && !errIn.ownFatal && !serrEn |=> !sendFatal;
   endproperty
   a_sec_fwd: assert property (p_sec_fwd) else $error("fatal forwarded while disabled");

   property p_cor;
      @(posedge ref_clk) disable iff (rst)
      clkEn && errIn.secCor |=> sendCor;
   endproperty
   a_cor: assert property (p_cor) else $error("correctable not forwarded");

   sequence s_intx_on;
      ownIntx && clkEn;
   endsequence
   property p_intx_off;
      @(posedge ref_clk) disable iff (rst)
      s_intx_on ##0 st.command[10] |=> !ownIntx && intxDeassertMsg;
   endproperty
   a_intx_off: assert property (p_intx_off) else $error("intx not deasserted");

   property p_ro_zero;
      @(posedge ref_clk) disable iff (rst)
      (command & ~bpc_pkg::BRIDGE_COMMAND_WMASK) == 16'h0000;
   endproperty
   a_ro_zero: assert property (p_ro_zero) else $error("fixed bit nonzero");

   property p_serr_set;
      @(posedge ref_clk) disable iff (rst)
      clkEn && sendFatal && $past(serrEn) |-> serrStatus;
   endproperty
   a_serr_set: assert property (p_serr_set) else $error("signalled error not set");

   // Command write steps shared by the byte lane, storage and clear checks
   sequence s_cmd_write;
      clkEn && cfgReq.wr && cmdSel;
   endsequence
   property p_byte_hold;
      @(posedge ref_clk) disable iff (rst)
      s_cmd_write ##0 !cfgReq.be[0] |=> command[7:0] == $past(command[7:0]);
   endproperty
   a_byte_hold: assert property (p_byte_hold) else $error("disabled byte lane changed");

   property p_parity_store;
      @(posedge ref_clk) disable iff (rst)
      s_cmd_write ##0 cfgReq.be[0]
      |=> command[bpc_pkg::PARITY_ERROR_ENABLE_BIT] == $past(cfgReq.wdata[bpc_pkg::PARITY_ERROR_ENABLE_BIT]);
   endproperty
   a_parity_store: assert property (p_parity_store) else $error("parity enable not stored");

   // A same-cycle error would set the bit again, so only a quiet cycle proves the clear
   sequence s_no_error_msg;
      !errIn.ownNonFatal && !errIn.ownFatal && !errIn.secNonFatal && !errIn.secFatal;
   endsequence
   property p_serr_clear;
      @(posedge ref_clk) disable iff (rst)
      s_cmd_write ##0 cfgReq.be[3] && cfgReq.wdata[16 + bpc_pkg::SIGNALLED_SERR_BIT] ##0 s_no_error_msg
      |=> !serrStatus;
   endproperty
   a_serr_clear: assert property (p_serr_clear) else $error("signalled error not cleared");

   property p_bm_ur_cpl;
      @(posedge ref_clk) disable iff (rst)
      clkEn && upReq.valid && memIo && upReq.nonPosted && !st.command[bpc_pkg::BUS_MASTERING_ENABLE_BIT]
      |=> upUrCpl;
   endproperty
   a_bm_ur_cpl: assert property (p_bm_ur_cpl) else $error("no unsupported request completion");

   property p_bm_other;
      @(posedge ref_clk) disable iff (rst)
      clkEn && upReq.valid && !memIo |=> upForward && !upUr && !upUrCpl;
   endproperty
   a_bm_other: assert property (p_bm_other) else $error("non memory request blocked");

   property p_own_report;
      @(posedge ref_clk) disable iff (rst)
      clkEn && errIn.ownNonFatal && (serrEn || errIn.devNonFatalEn) |=> sendNonFatal;
   endproperty
   a_own_report: assert property (p_own_report) else $error("own error not reported");

   property p_own_quiet;
      @(posedge ref_clk) disable iff (rst)
      clkEn && !serrEn && !errIn.devFatalEn |=> !sendFatal;
   endproperty
   a_own_quiet: assert property (p_own_quiet) else $error("fatal reported while disabled");

   property p_intx_fwd;
      @(posedge ref_clk) disable iff (rst)
      clkEn |=> fwdIntx == $past(secIntx);
   endproperty
   a_intx_fwd: assert property (p_intx_fwd) else $error("forwarded interrupt altered");

   // Checked one edge after release, before any request can land
   sequence s_reset_released;
      $fell(rst);
   endsequence
   property p_reset_zero;
      @(posedge ref_clk)
      s_reset_released |-> command == 16'h0000 && !serrStatus && !cfgRvalid;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");
endmodule

/* core/bpc_pkg.sv */
// Package for the bridge port command register block
package bpc_pkg;
   localparam logic [11:0] BRIDGE_COMMAND_OFFSET = 12'h004;
   localparam logic [15:0] BRIDGE_COMMAND_RESET  = 16'h0000;
   localparam logic [15:0] BRIDGE_COMMAND_WMASK  = 16'h0547;
   localparam int IO_SPACE_ENABLE_BIT      = 0;
   localparam int MEMORY_SPACE_ENABLE_BIT  = 1;
   localparam int BUS_MASTERING_ENABLE_BIT = 2;
   localparam int PARITY_ERROR_ENABLE_BIT  = 6;
   localparam int SYSTEM_ERROR_ENABLE_BIT  = 8;
   localparam int INTERRUPT_DISABLE_BIT    = 10;
   localparam int SIGNALLED_SERR_BIT       = 14;
   localparam logic [11:0] BRIDGE_STATUS_OFFSET = 12'h006;

   // Upstream request kinds arriving from the secondary side
   typedef enum logic [2:0] {
      BPC_REQ_MEM, BPC_REQ_IO, BPC_REQ_MSI, BPC_REQ_CPL, BPC_REQ_MSG, BPC_REQ_CFG
   } bpc_req_kind_t;

   // Configuration access: byte address, byte enables
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bpc_cfg_req_t;

   // Upstream request description
   typedef struct packed {
      logic          valid;
      bpc_req_kind_t kind;
      logic          nonPosted;
   } bpc_up_req_t;

   // Error message inputs and reporting enables
   typedef struct packed {
      logic ownNonFatal;
      logic ownFatal;
      logic devNonFatalEn;
      logic devFatalEn;
      logic secNonFatal;
      logic secFatal;
      logic secCor;
   } bpc_err_in_t;

   typedef struct packed {
      logic [15:0] command;
      logic        serrStatus;
      logic [31:0] rdata;
      logic        rvalid;
      logic        ioClaim;
      logic        memClaim;
      logic        upForward;
      logic        upUr;
      logic        upUrCpl;
      logic        sendNonFatal;
      logic        sendFatal;
      logic        sendCor;
      logic        ownIntx;
      logic        intxAssertMsg;
      logic        intxDeassertMsg;
      logic        fwdIntx;
   } bpc_state_t;
endpackage
